// ---- src/pfh_regs.svh ----
`ifndef PFH_REGS_SVH
`define PFH_REGS_SVH

// ----------------------------------------------------------------
// Clock and cycle conversion
// ----------------------------------------------------------------
`define PFH_CLK_MHZ        50
`define PFH_CYC_MIN(ns)    ((((ns) * `PFH_CLK_MHZ) + 999) / 1000)
`define PFH_US_CYC(us)     ((us) * `PFH_CLK_MHZ)

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PFH_T_WINDOW_US    150
`define PFH_T_PWRUP_US     5000
`define PFH_T_WP_NS        100
`define PFH_T_WPH_NS       60
`define PFH_T_ACC_NS       150
`define PFH_T_GAP_NS       40
`define PFH_SYNC_LAT       3
`define PFH_WIN_GUARD_CYC  16
`define PFH_SETTLE_CYC     16

// ----------------------------------------------------------------
// Pin layout
// ----------------------------------------------------------------
`define PFH_ADDR_W         19
`define PFH_SECTOR_LSB     8
`define PFH_TOGGLE_BIT     6

// ----------------------------------------------------------------
// Command sequence constants
// ----------------------------------------------------------------
`define PFH_SEQ_ADDR1      19'h05555
`define PFH_SEQ_ADDR2      19'h02aaa
`define PFH_SEQ_DATA1      8'haa
`define PFH_SEQ_DATA2      8'h55
`define PFH_CMD_WP_ON      8'ha0
`define PFH_CMD_SETUP      8'h80
`define PFH_CMD_WP_OFF     8'h20
`define PFH_CMD_ERASE      8'h10
`define PFH_CMD_LOCK       8'h40
`define PFH_CMD_ID_IN      8'h90
`define PFH_CMD_ID_OUT     8'hf0
`define PFH_LOCK_DATA      8'h00
`define PFH_BOOT_LO_ADDR   19'h00000
`define PFH_BOOT_HI_ADDR   19'h7c000
`define PFH_LOCK_STAT_LO   19'h00002
`define PFH_LOCK_STAT_HI   19'h7fff2
`define PFH_LOCK_STAT_SET  8'hff

`endif

// ---- src/pfh_pkg.sv ----
`include "pfh_regs.svh"

package pfh_pkg;

	// ----------------------------------------------------------------
	// Request, answer and state types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_LOAD, OP_WP_ON, OP_WP_OFF, OP_ERASE,
		OP_LOCK_LO, OP_LOCK_HI, OP_ID_IN, OP_ID_OUT
	} pfh_op_e;

	typedef struct packed {
		pfh_op_e                 op;
		logic [`PFH_ADDR_W-1:0]  addr;
		logic [7:0]              data;
	} pfh_req_s;

	typedef struct packed {
		logic [7:0] data;
		logic       refused;
	} pfh_rsp_s;

	typedef struct packed {
		logic [`PFH_ADDR_W-1:0]  addr;
		logic [7:0]              data;
	} pfh_word_s;

	typedef enum logic [3:0] {
		ST_POWERUP, ST_IDLE, ST_DISPATCH, ST_SETUP, ST_STROBE,
		ST_HOLD, ST_LOADED, ST_ACCESS, ST_GAP
	} pfh_state_e;

endpackage : pfh_pkg

// ---- src/pfh_sync.sv ----
`timescale 1ns/100ps

module pfh_sync #(
	parameter int W = 8
) (
	// Clock, enable and reset
	input  wire logic          i_sys_clk,
	input  wire logic          i_clk_en,
	input  wire logic          i_reset,
	// Asynchronous input and its synchronised view
	input  wire logic [W-1:0]  i_d,
	output logic      [W-1:0]  o_q,
	output logic               o_stable
);

	if (W < 1) begin : g_bad_width
		$error("pfh_sync width must be at least one");
	end

	logic [W-1:0] s1;
	logic [W-1:0] s2;

	// The change is trusted once the second and third stages agree.
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			s1       <= '0;
			s2       <= '0;
			o_q      <= '0;
			o_stable <= 1'b0;
		end else if (i_clk_en) begin
			s1       <= i_d;
			s2       <= s1;
			o_q      <= s2;
			o_stable <= (s2 == o_q);
		end
	end

endmodule : pfh_sync

// ---- src/pfh_ctrl.sv ----
`timescale 1ns/100ps
`include "pfh_regs.svh"

// Notes on behaviour
// - Host loads a byte with a write strobe low pulse, chip select low, output enable high.
// - Next load must fall within 150 us of previous rise, else programming starts.
// - Sector address bits stay valid at every falling strobe edge of one load burst.
// - With write protection on, each program cycle begins with the three unlock commands.
// - Protection command bytes follow the same load window timing as sector loads.

module pfh_ctrl #(
	parameter int P_WINDOW_CYC = `PFH_US_CYC(`PFH_T_WINDOW_US),
	parameter int P_PWRUP_CYC  = `PFH_US_CYC(`PFH_T_PWRUP_US)
) (
	// Clock, enable and reset
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_clk_en,
	input  wire logic                    i_reset,
	// Configuration
	input  wire logic                    i_wp_strap,
	// Request port
	input  wire logic                    i_req_valid,
	input  wire pfh_pkg::pfh_req_s       i_req,
	output logic                         o_req_ready,
	// Answer port
	output logic                         o_rsp_valid,
	output pfh_pkg::pfh_rsp_s            o_rsp,
	output logic                         o_busy,
	output logic                         o_wp_on,
	// Flash pins
	output logic [`PFH_ADDR_W-1:0]       o_addr,
	output logic                         o_ce_n,
	output logic                         o_oe_n,
	output logic                         o_we_n,
	output logic [7:0]                   o_dq,
	output logic                         o_dq_oe,
	input  wire logic [7:0]              i_dq
);

	localparam int TW = $clog2(P_PWRUP_CYC + P_WINDOW_CYC + 64);
	localparam logic [4:0] WP_CYC  = 5'(`PFH_CYC_MIN(`PFH_T_WP_NS));
	localparam logic [4:0] WPH_CYC = 5'(`PFH_CYC_MIN(`PFH_T_WPH_NS));
	localparam logic [4:0] ACC_CYC = 5'(`PFH_CYC_MIN(`PFH_T_ACC_NS) + `PFH_SYNC_LAT);
	localparam logic [4:0] GAP_CYC = 5'(`PFH_CYC_MIN(`PFH_T_GAP_NS));
	localparam logic [TW-1:0] ACCEPT_LIM = TW'(P_WINDOW_CYC - `PFH_WIN_GUARD_CYC);
	localparam logic [TW-1:0] CLOSE_LIM  = TW'(P_WINDOW_CYC + `PFH_SETTLE_CYC);
	localparam logic [TW-1:0] PWRUP_LIM  = TW'(P_PWRUP_CYC - 1);

	if (P_WINDOW_CYC <= `PFH_WIN_GUARD_CYC || P_PWRUP_CYC < 1) begin : g_bad_param
		$error("pfh_ctrl window or power-up count too small");
	end

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	logic [7:0] dq_q;
	logic       dq_stable;

	pfh_sync #(.W(8)) u_dq_sync (
		.i_sys_clk (i_sys_clk),
		.i_clk_en  (i_clk_en),
		.i_reset   (i_reset),
		.i_d       (i_dq),
		.o_q       (dq_q),
		.o_stable  (dq_stable)
	);

	// ----------------------------------------------------------------
	// Command sequence table
	// ----------------------------------------------------------------
	function automatic pfh_pkg::pfh_word_s step_word(pfh_pkg::pfh_req_s r, logic [2:0] k);
		pfh_pkg::pfh_word_s w;
		w.addr = (k == 3'h1 || k == 3'h4) ? `PFH_SEQ_ADDR2 : `PFH_SEQ_ADDR1;
		w.data = (k == 3'h1 || k == 3'h4) ? `PFH_SEQ_DATA2 : `PFH_SEQ_DATA1;
		if (k == 3'h2) begin
			unique case (r.op)
				pfh_pkg::OP_ID_IN:  w.data = `PFH_CMD_ID_IN;
				pfh_pkg::OP_ID_OUT: w.data = `PFH_CMD_ID_OUT;
				pfh_pkg::OP_LOAD, pfh_pkg::OP_WP_ON: w.data = `PFH_CMD_WP_ON;
				default: w.data = `PFH_CMD_SETUP;
			endcase
		end else if (k == 3'h5) begin
			unique case (r.op)
				pfh_pkg::OP_WP_OFF: w.data = `PFH_CMD_WP_OFF;
				pfh_pkg::OP_ERASE:  w.data = `PFH_CMD_ERASE;
				default: w.data = `PFH_CMD_LOCK;
			endcase
		end else if (k == 3'h3 && r.op == pfh_pkg::OP_LOAD) begin
			w.addr = r.addr;
			w.data = r.data;
		end else if (k == 3'h6) begin
			w.addr = (r.op == pfh_pkg::OP_LOCK_HI) ? `PFH_BOOT_HI_ADDR : `PFH_BOOT_LO_ADDR;
			w.data = `PFH_LOCK_DATA;
		end
		return w;
	endfunction : step_word

	function automatic logic [2:0] last_step(pfh_pkg::pfh_op_e op);
		unique case (op)
			pfh_pkg::OP_LOAD: return 3'h3;
			pfh_pkg::OP_WP_OFF, pfh_pkg::OP_ERASE: return 3'h5;
			pfh_pkg::OP_LOCK_LO, pfh_pkg::OP_LOCK_HI: return 3'h6;
			default: return 3'h2;
		endcase
	endfunction : last_step

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	pfh_pkg::pfh_state_e state;
	pfh_pkg::pfh_req_s   cur;
	pfh_pkg::pfh_word_s  first_w;
	pfh_pkg::pfh_word_s  next_w;
	logic [2:0]          step;
	logic [2:0]          first_step;
	logic [4:0]          cnt;
	logic [TW-1:0]       tmr;
	logic [`PFH_ADDR_W-1:0] last_addr;
	logic                burst_open;
	logic                polling;
	logic                poll_done;
	logic                have_prev;
	logic                prev_toggle;
	logic                pend;
	logic                strap_done;
	logic                lock_lo;
	logic                lock_hi;
	logic                same_sector;

	// A load inside an open burst skips the unlock prefix already given.
	assign first_step  = (cur.op == pfh_pkg::OP_LOAD && (burst_open || !o_wp_on)) ? 3'h3 : 3'h0;
	assign first_w     = step_word(cur, first_step);
	assign next_w      = step_word(cur, step + 3'h1);
	assign same_sector = (i_req.addr[`PFH_ADDR_W-1:`PFH_SECTOR_LSB] == last_addr[`PFH_ADDR_W-1:`PFH_SECTOR_LSB]);

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= pfh_pkg::ST_POWERUP;
			cur <= '0;
			step <= 3'h0;
			cnt <= 5'h0;
			tmr <= '0;
			last_addr <= '0;
			burst_open <= 1'b0;
			polling <= 1'b0;
			poll_done <= 1'b0;
			have_prev <= 1'b0;
			prev_toggle <= 1'b0;
			pend <= 1'b0;
			strap_done <= 1'b0;
			lock_lo <= 1'b0;
			lock_hi <= 1'b0;
			o_req_ready <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp <= '0;
			o_busy <= 1'b0;
			o_wp_on <= 1'b0;
			o_addr <= '0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_rsp_valid <= 1'b0;
			unique case (state)
				pfh_pkg::ST_POWERUP: begin
					// Protection state survives power cycles, so the strap tells where it stands.
					if (!strap_done) begin
						o_wp_on <= i_wp_strap;
						strap_done <= 1'b1;
					end
					tmr <= tmr + TW'(1);
					if (tmr >= PWRUP_LIM) begin
						state <= pfh_pkg::ST_IDLE;
						o_req_ready <= 1'b1;
					end
				end
				pfh_pkg::ST_IDLE: begin
					if (i_req_valid) begin
						cur <= i_req;
						o_req_ready <= 1'b0;
						state <= pfh_pkg::ST_DISPATCH;
					end
				end
				pfh_pkg::ST_DISPATCH: begin
					pend <= 1'b0;
					if (cur.op == pfh_pkg::OP_READ) begin
						o_addr <= cur.addr;
						o_ce_n <= 1'b0;
						o_oe_n <= 1'b0;
						cnt <= ACC_CYC;
						polling <= 1'b0;
						state <= pfh_pkg::ST_ACCESS;
					end else if (cur.op == pfh_pkg::OP_ERASE && (lock_lo || lock_hi)) begin
						o_rsp <= '{data: 8'h00, refused: 1'b1};
						o_rsp_valid <= 1'b1;
						o_req_ready <= 1'b1;
						state <= pfh_pkg::ST_IDLE;
					end else begin
						step <= first_step;
						o_addr <= first_w.addr;
						o_dq <= first_w.data;
						o_dq_oe <= 1'b1;
						o_oe_n <= 1'b1;
						o_ce_n <= 1'b0;
						burst_open <= 1'b1;
						state <= pfh_pkg::ST_SETUP;
					end
				end
				pfh_pkg::ST_SETUP: begin
					o_we_n <= 1'b0;
					cnt <= WP_CYC - 5'h1;
					state <= pfh_pkg::ST_STROBE;
				end
				pfh_pkg::ST_STROBE: begin
					if (cnt == 5'h0) begin
						o_we_n <= 1'b1;
						cnt <= WPH_CYC - 5'h1;
						tmr <= '0;
						state <= pfh_pkg::ST_HOLD;
					end else begin
						cnt <= cnt - 5'h1;
					end
				end
				pfh_pkg::ST_HOLD: begin
					o_ce_n <= 1'b1;
					o_dq_oe <= 1'b0;
					tmr <= tmr + TW'(1);
					if (cnt != 5'h0) begin
						cnt <= cnt - 5'h1;
					end else if (step == last_step(cur.op)) begin
						last_addr <= o_addr;
						if (cur.op == pfh_pkg::OP_WP_ON) o_wp_on <= 1'b1;
						if (cur.op == pfh_pkg::OP_WP_OFF) o_wp_on <= 1'b0;
						if (cur.op == pfh_pkg::OP_LOCK_LO) lock_lo <= 1'b1;
						if (cur.op == pfh_pkg::OP_LOCK_HI) lock_hi <= 1'b1;
						o_rsp <= '{data: cur.data, refused: 1'b0};
						o_rsp_valid <= 1'b1;
						o_busy <= 1'b1;
						o_req_ready <= 1'b1;
						state <= pfh_pkg::ST_LOADED;
					end else begin
						step <= step + 3'h1;
						o_addr <= next_w.addr;
						o_dq <= next_w.data;
						o_dq_oe <= 1'b1;
						o_ce_n <= 1'b0;
						state <= pfh_pkg::ST_SETUP;
					end
				end
				pfh_pkg::ST_LOADED: begin
					tmr <= tmr + TW'(1);
					// Ready drops a guard ahead of the window so that an accepted load still falls in time.
					o_req_ready <= !pend && !(o_req_ready && i_req_valid) && (tmr + TW'(1) < ACCEPT_LIM);
					if (o_req_ready && i_req_valid) begin
						cur <= i_req;
						// Only a load burst, or the unlock that opens one, may take further data bytes.
						if (i_req.op == pfh_pkg::OP_LOAD && same_sector
							&& (cur.op == pfh_pkg::OP_LOAD || cur.op == pfh_pkg::OP_WP_ON)) begin
							state <= pfh_pkg::ST_DISPATCH;
						end else begin
							pend <= 1'b1;
						end
					end else if (tmr >= CLOSE_LIM) begin
						// The window has lapsed and the device is programming; poll it out.
						burst_open <= 1'b0;
						o_req_ready <= 1'b0;
						o_addr <= last_addr;
						o_ce_n <= 1'b0;
						o_oe_n <= 1'b0;
						cnt <= ACC_CYC;
						polling <= 1'b1;
						have_prev <= 1'b0;
						poll_done <= 1'b0;
						state <= pfh_pkg::ST_ACCESS;
					end
				end
				pfh_pkg::ST_ACCESS: begin
					if (cnt != 5'h0) begin
						cnt <= cnt - 5'h1;
					end else if (dq_stable) begin
						o_ce_n <= 1'b1;
						o_oe_n <= 1'b1;
						cnt <= GAP_CYC - 5'h1;
						state <= pfh_pkg::ST_GAP;
						if (polling) begin
							have_prev <= 1'b1;
							prev_toggle <= dq_q[`PFH_TOGGLE_BIT];
							poll_done <= have_prev && (prev_toggle == dq_q[`PFH_TOGGLE_BIT]);
						end else begin
							o_rsp <= '{data: dq_q, refused: 1'b0};
							o_rsp_valid <= 1'b1;
							if (o_addr == `PFH_LOCK_STAT_LO && dq_q == `PFH_LOCK_STAT_SET) lock_lo <= 1'b1;
							if (o_addr == `PFH_LOCK_STAT_HI && dq_q == `PFH_LOCK_STAT_SET) lock_hi <= 1'b1;
						end
					end
				end
				pfh_pkg::ST_GAP: begin
					if (cnt != 5'h0) begin
						cnt <= cnt - 5'h1;
					end else if (polling && !poll_done) begin
						o_ce_n <= 1'b0;
						o_oe_n <= 1'b0;
						cnt <= ACC_CYC;
						state <= pfh_pkg::ST_ACCESS;
					end else begin
						polling <= 1'b0;
						o_busy <= 1'b0;
						if (pend) begin
							state <= pfh_pkg::ST_DISPATCH;
						end else begin
							o_req_ready <= 1'b1;
							state <= pfh_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [TW-1:0] since_rise;
	logic [1:0]    fall_idx;

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			since_rise <= '0;
			fall_idx <= 2'h0;
		end else if (i_clk_en) begin
			since_rise <= (!o_we_n) ? '0 : since_rise + TW'(1);
			if (!burst_open) fall_idx <= 2'h0;
			else if (state == pfh_pkg::ST_SETUP && fall_idx != 2'h3) fall_idx <= fall_idx + 2'h1;
		end
	end

	default clocking cb @(posedge i_sys_clk iff i_clk_en); endclocking
	default disable iff (i_reset);

	sequence s_we_pulse;
		(!o_we_n) [*5] ##1 o_we_n;
	endsequence

	sequence s_second_unlock;
		##[1:20] ($fell(o_we_n) && o_addr == `PFH_SEQ_ADDR2 && o_dq == `PFH_SEQ_DATA2);
	endsequence

	a_strobe_shape: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
		else $error("write strobe low without chip select low and output enable high");
	a_strobe_width: assert property ($fell(o_we_n) |-> s_we_pulse)
		else $error("write strobe pulse not five cycles long");
	a_addr_steady: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq))
		else $error("address or data moved while write strobe low");
	a_window_next: assert property ($fell(o_we_n) && fall_idx > 2'h1 |-> since_rise < TW'(P_WINDOW_CYC))
		else $error("load began after the load window");
	a_unlock_first: assert property ($fell(o_we_n) && fall_idx == 2'h1 && o_wp_on && cur.op == pfh_pkg::OP_LOAD
		&& step == 3'h0 |-> o_addr == `PFH_SEQ_ADDR1 && o_dq == `PFH_SEQ_DATA1)
		else $error("protected program cycle lacks first unlock byte");
	a_unlock_second: assert property (o_wp_on && cur.op == pfh_pkg::OP_LOAD && step == 3'h0 && $fell(o_we_n)
		|-> s_second_unlock)
		else $error("protected program cycle lacks second unlock byte");

endmodule : pfh_ctrl

// ---- bench/pfh_flash_model.sv ----
`timescale 1ns/100ps
`include "pfh_regs.svh"

module pfh_flash_model #(
	parameter int         WIN_NS   = 4000,
	parameter int         PROG_NS  = 3000,
	parameter int         PWR_NS   = 300,
	parameter logic [7:0] MFR_CODE = 8'h3c,  // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'h96   // Arbitrary value.
) (
	// Flash pins
	input  wire logic [18:0] i_addr,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [7:0]  i_dq,
	output logic [7:0]       o_dq,
	// Protection state kept by the chip
	output logic             o_wp
);
	// ----------------------------------------------------------------
	// Array, load buffer and status
	// ----------------------------------------------------------------
	logic [7:0]  mem [int];
	logic [18:0] qa [$];
	logic [7:0]  qd [$];
	logic [18:0] la;
	logic [7:0]  lastd = 8'h00;
	logic [7:0]  rd;
	logic        busy = 1'b0;
	logic        tog = 1'b0;
	logic        armed = 1'b0;
	logic        idm = 1'b0;
	logic        lk_lo = 1'b0;
	logic        lk_hi = 1'b0;
	realtime     t_fall = 0;
	realtime     t_rise = 0;

	initial o_wp = 1'b0;

	task automatic commit();
		int          n;
		int          first;
		logic        pre;
		logic [10:0] sec;
		n = qd.size();
		pre = n >= 3 && qa[0] == `PFH_SEQ_ADDR1 && qd[0] == `PFH_SEQ_DATA1 && qa[1] == `PFH_SEQ_ADDR2
			&& qd[1] == `PFH_SEQ_DATA2;
		first = (o_wp || pre) ? n : 0;
		if (pre && qd[2] == `PFH_CMD_WP_ON) begin
			o_wp = 1'b1;
			first = 3;
		end
		else if (pre && qd[2] == `PFH_CMD_ID_IN) idm = 1'b1;
		else if (pre && qd[2] == `PFH_CMD_ID_OUT) idm = 1'b0;
		else if (pre && n >= 6 && qd[5] == `PFH_CMD_WP_OFF) o_wp = 1'b0;
		else if (pre && n >= 6 && qd[5] == `PFH_CMD_ERASE && !lk_lo && !lk_hi) mem.delete();
		else if (pre && n == 7 && qd[5] == `PFH_CMD_LOCK) begin
			lk_lo = lk_lo | (qa[6] < 19'h04000);
			lk_hi = lk_hi | (qa[6] >= 19'h7c000);
		end
		if (first < n && $realtime >= PWR_NS) begin
			sec = qa[first][18:8];
			if (!(lk_lo && sec < 11'h040) && !(lk_hi && sec >= 11'h7c0)) begin
				for (int i = 0; i < 256; i++) mem[{sec, i[7:0]}] = 8'hff;
				for (int i = first; i < n; i++) if (qa[i][18:8] == sec) mem[qa[i]] = qd[i];
			end
		end
	endtask : commit

	// ----------------------------------------------------------------
	// Byte loads and the load window
	// ----------------------------------------------------------------
	always @(negedge i_we_n) begin
		t_fall = $realtime;
		la = i_addr;
	end

	always @(posedge i_we_n) begin
		// Short glitches and inhibited strobes never reach the buffer.
		if (!i_ce_n && i_oe_n && !busy && $realtime - t_fall >= 15) begin
			qa.push_back(la);
			qd.push_back(i_dq);
			lastd = i_dq;
			t_rise = $realtime;
			armed = 1'b1;
		end
	end

	always #100 if (armed && i_we_n && t_fall < t_rise && $realtime - t_rise >= WIN_NS) begin
		armed = 1'b0;
		commit();
		qa.delete();
		qd.delete();
		busy = 1'b1;
		#PROG_NS busy = 1'b0;
	end

	// ----------------------------------------------------------------
	// Reads and status polling
	// ----------------------------------------------------------------
	always @(negedge i_oe_n) if (busy) tog = ~tog;

	always @(i_addr, busy, tog, idm, lk_lo, lk_hi, lastd) begin
		if (busy) rd = {~lastd[7], tog, lastd[5:0]};
		else if (idm && i_addr == 19'h00000) rd = MFR_CODE;
		else if (idm && i_addr == 19'h00001) rd = DEV_CODE;
		else if (idm && i_addr == `PFH_LOCK_STAT_LO) rd = {7'h7f, lk_lo};
		else if (idm && i_addr == `PFH_LOCK_STAT_HI) rd = {7'h7f, lk_hi};
		else rd = mem.exists(i_addr) ? mem[i_addr] : 8'hff;
	end

	// A released bus shows the inverse of the read value, so a host that samples it is caught.
	always @(i_ce_n, i_oe_n, i_we_n, rd) begin
		if (!i_ce_n && !i_oe_n && i_we_n) o_dq = rd;
		else o_dq = ~rd;
	end

endmodule : pfh_flash_model

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`include "pfh_regs.svh"

module testbench;
	localparam int WIN_CYC = 200;
	localparam int PWR_CYC = 20;
	localparam int LIMIT   = 60000;
	localparam int NROWS   = 24;

	typedef struct packed {
		pfh_pkg::pfh_op_e op;
		logic [18:0]      addr;
		logic [7:0]       data;
		logic [7:0]       exp;
	} pfh_row_s;

	logic               clk = 1'b0;
	logic               reset = 1'b1;
	logic               clk_en = 1'b1;
	logic               req_valid = 1'b0;
	pfh_pkg::pfh_req_s  req = '0;
	logic               ready, rsp_valid, busy, wp_on, wp_chip;
	pfh_pkg::pfh_rsp_s  rsp;
	pfh_pkg::pfh_rsp_s  r;
	logic [18:0]        addr;
	logic               ce_n, oe_n, we_n, dq_oe;
	logic [7:0]         dq_host, dq_dev, dq_bus;
	pfh_row_s           rows [0:NROWS-1];
	int                 err_total = 0;
	int                 samples_checked = 0;
	int                 cyc = 0;

	initial forever #10 clk = ~clk;

	assign dq_bus = dq_oe ? dq_host : dq_dev;

	pfh_ctrl #(.P_WINDOW_CYC(WIN_CYC), .P_PWRUP_CYC(PWR_CYC)) dut (
		.i_sys_clk(clk), .i_clk_en(clk_en), .i_reset(reset), .i_wp_strap(wp_chip),
		.i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
		.o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_busy(busy), .o_wp_on(wp_on),
		.o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_dq(dq_host), .o_dq_oe(dq_oe), .i_dq(dq_bus)
	);

	pfh_flash_model #(.WIN_NS(WIN_CYC * 20)) flash (
		.i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_dq(dq_bus), .o_dq(dq_dev), .o_wp(wp_chip)
	);

	// ----------------------------------------------------------------
	// Compare, request and closing tasks
	// ----------------------------------------------------------------
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t byte got %h expected %h", $time, got, exp);
		end
	endtask : check_byte

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t bit got %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude

	// The request is held from a falling edge until ready is seen, so it is taken at the next rising edge.
	task automatic do_req(input pfh_pkg::pfh_op_e op, input logic [18:0] a, input logic [7:0] d,
		output pfh_pkg::pfh_rsp_s rr);
		// A hang is left to the cycle watchdog, which counts it as a mismatch.
		@(negedge clk);
		req_valid = 1'b1;
		req = '{op, a, d};
		while (ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1) @(negedge clk);
		rr = rsp;
	endtask : do_req

	// ----------------------------------------------------------------
	// Watchdog and pin monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			$display("ERROR %0t run did not finish", $time);
			conclude();
		end
	end

	always @(negedge clk) if (we_n === 1'b0) check_bit(oe_n & ~ce_n & dq_oe, 1'b1);

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rows = '{
			'{pfh_pkg::OP_LOAD,    19'h01203, 8'h5a, 8'h00},
			'{pfh_pkg::OP_LOAD,    19'h01201, 8'hc3, 8'h00},
			'{pfh_pkg::OP_LOAD,    19'h01300, 8'h77, 8'h00},
			'{pfh_pkg::OP_READ,    19'h01203, 8'h00, 8'h5a},
			'{pfh_pkg::OP_READ,    19'h01201, 8'h00, 8'hc3},
			'{pfh_pkg::OP_READ,    19'h01202, 8'h00, 8'hff},
			'{pfh_pkg::OP_READ,    19'h01300, 8'h00, 8'h77},
			'{pfh_pkg::OP_WP_ON,   19'h00000, 8'h00, 8'h00},
			'{pfh_pkg::OP_LOAD,    19'h02005, 8'h11, 8'h00},
			'{pfh_pkg::OP_READ,    19'h02005, 8'h00, 8'h11},
			'{pfh_pkg::OP_ERASE,   19'h00000, 8'h00, 8'h00},
			'{pfh_pkg::OP_READ,    19'h01203, 8'h00, 8'hff},
			'{pfh_pkg::OP_WP_OFF,  19'h00000, 8'h00, 8'h00},
			'{pfh_pkg::OP_LOAD,    19'h7c010, 8'h42, 8'h00},
			'{pfh_pkg::OP_READ,    19'h7c010, 8'h00, 8'h42},
			'{pfh_pkg::OP_LOCK_HI, 19'h7c000, 8'h00, 8'h00},
			'{pfh_pkg::OP_LOAD,    19'h7c010, 8'h99, 8'h00},
			'{pfh_pkg::OP_READ,    19'h7c010, 8'h00, 8'h42},
			'{pfh_pkg::OP_ERASE,   19'h00000, 8'h00, 8'h01},
			'{pfh_pkg::OP_ID_IN,   19'h00000, 8'h00, 8'h00},
			'{pfh_pkg::OP_READ,    19'h00000, 8'h00, 8'h3c},
			'{pfh_pkg::OP_READ,    `PFH_LOCK_STAT_LO, 8'h00, 8'hfe},
			'{pfh_pkg::OP_READ,    `PFH_LOCK_STAT_HI, 8'h00, 8'hff},
			'{pfh_pkg::OP_ID_OUT,  19'h00000, 8'h00, 8'h00}
		};
		repeat (2) @(negedge clk);
		check_bit(ce_n & oe_n & we_n & ~dq_oe & ~ready & ~rsp_valid, 1'b1);
		repeat (2) @(negedge clk);
		reset = 1'b0;
		repeat (PWR_CYC - 5) @(negedge clk);
		check_bit(ready, 1'b0);
		$display("reset test done");
		for (int i = 0; i < NROWS; i++) begin
			do_req(rows[i].op, rows[i].addr, rows[i].data, r);
			if (rows[i].op == pfh_pkg::OP_READ) check_byte(r.data, rows[i].exp);
			else check_bit(r.refused, rows[i].exp[0]);
		end
		$display("table test done");
		do_req(pfh_pkg::OP_WP_ON, 19'h00000, 8'h00, r);
		check_bit(busy, 1'b1);
		// The chip must finish storing the protection state before the host forgets it.
		while (busy !== 1'b0) @(negedge clk);
		reset = 1'b1;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		clk_en = 1'b0;
		repeat (PWR_CYC + 10) @(negedge clk);
		check_bit(ready, 1'b0);
		clk_en = 1'b1;
		do_req(pfh_pkg::OP_ERASE, 19'h00000, 8'h00, r);
		check_bit(wp_on, 1'b1);
		check_bit(r.refused, 1'b0);
		do_req(pfh_pkg::OP_READ, 19'h7c010, 8'h00, r);
		check_byte(r.data, 8'h42);
		do_req(pfh_pkg::OP_LOAD, 19'h03000, 8'h5c, r);
		do_req(pfh_pkg::OP_READ, 19'h03000, 8'h00, r);
		check_byte(r.data, 8'h5c);
		do_req(pfh_pkg::OP_LOCK_LO, 19'h00000, 8'h00, r);
		do_req(pfh_pkg::OP_ERASE, 19'h00000, 8'h00, r);
		check_bit(r.refused, 1'b1);
		$display("second reset test done");
		conclude();
	end

endmodule : testbench
